// ===== shared/gfb_pkg.sv
// Constants shared by the general-purpose FIFO bank
package gfb_pkg;
  localparam int ADDR_W = 17;
  localparam int IDX_W = 15;
  localparam int DATA_W = 8;
  localparam int NUM_FIFOS = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] FIFO_FULL_COUNT = 4'h8;

  // Register indices; the byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_SILICON_REVISION = 15'h7F06;
  localparam logic [IDX_W-1:0] IDX_DEVICE_IDENTIFICATION = 15'h7F07;
  localparam logic [IDX_W-1:0] IDX_FIFO_ONE_DATA = 15'h7F10;
  localparam logic [IDX_W-1:0] IDX_FIFO_ONE_FLAGS = 15'h7F11;
  localparam logic [IDX_W-1:0] IDX_FIFO_TWO_DATA = 15'h7F12;
  localparam logic [IDX_W-1:0] IDX_FIFO_TWO_FLAGS = 15'h7F13;
  localparam logic [IDX_W-1:0] IDX_FIFO_THREE_DATA = 15'h7F14;
  localparam logic [IDX_W-1:0] IDX_FIFO_THREE_FLAGS = 15'h7F15;
  localparam logic [IDX_W-1:0] IDX_FIFO_FOUR_DATA = 15'h7F16;
  localparam logic [IDX_W-1:0] IDX_FIFO_FOUR_FLAGS = 15'h7F17;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 15'h7F20;
  localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 15'h7F21;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR = 15'h7F22;
  // Data and flags registers alternate, one pair per FIFO
  localparam logic [IDX_W-1:0] IDX_FIFO_STRIDE = 15'h0002;

  // Flags register layout
  localparam int FLAG_EMPTY_BIT = 0;
  localparam int FLAG_FULL_BIT = 1;
  localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h01;

  // Interrupt status layout: overflow bits 3:0, underflow bits 7:4
  localparam int IRQ_W = 8;
  localparam int IRQ_OVERFLOW_BASE = 0;
  localparam int IRQ_UNDERFLOW_BASE = 4;
  localparam logic [IRQ_W-1:0] IRQ_STATUS_RESET = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_ENABLE_RESET = 8'h00;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } gfb_bus_state_t;
endpackage : gfb_pkg

// ===== rtl/gfb_fifo.sv
// One byte-wide FIFO of the general-purpose FIFO bank
`timescale 1ns/10ps
module gfb_fifo (
  input wire logic clk,
  input wire logic nrst,
  input wire logic push,
  input wire logic pop,
  input wire logic [gfb_pkg::DATA_W-1:0] wdata,
  output logic [gfb_pkg::DATA_W-1:0] rdata,
  output logic full,
  output logic empty
);
  logic [gfb_pkg::DATA_W-1:0] mem_reg [0:gfb_pkg::FIFO_DEPTH-1];
  logic [gfb_pkg::DATA_W-1:0] mem_next [0:gfb_pkg::FIFO_DEPTH-1];
  logic [gfb_pkg::PTR_W-1:0] wptr_reg, wptr_next;
  logic [gfb_pkg::PTR_W-1:0] rptr_reg, rptr_next;
  logic [gfb_pkg::CNT_W-1:0] count_reg, count_next;
  logic push_ok;
  logic pop_ok;

  assign full = (count_reg == gfb_pkg::FIFO_FULL_COUNT);
  assign empty = (count_reg == 4'h0);
  // Empty FIFO reads as zero rather than a stale entry
  assign rdata = empty ? 8'h00 : mem_reg[rptr_reg];
  assign push_ok = push & ~full;
  assign pop_ok = pop & ~empty;

  always_comb begin
    mem_next = mem_reg;
    wptr_next = wptr_reg;
    rptr_next = rptr_reg;
    count_next = count_reg;
    if (push_ok) begin
      mem_next[wptr_reg] = wdata;
      wptr_next = wptr_reg + 3'h1;
    end
    if (pop_ok) begin
      rptr_next = rptr_reg + 3'h1;
    end
    if (push_ok && !pop_ok) begin
      count_next = count_reg + 4'h1;
    end else if (pop_ok && !push_ok) begin
      count_next = count_reg - 4'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < gfb_pkg::FIFO_DEPTH; i++) begin
        mem_reg[i] <= 8'h00;
      end
      wptr_reg <= 3'h0;
      rptr_reg <= 3'h0;
      count_reg <= 4'h0;
    end else begin
      mem_reg <= mem_next;
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      count_reg <= count_next;
    end
  end
endmodule : gfb_fifo

// ===== rtl/gfb_top.sv
// Bank of four byte FIFOs with identification registers behind an APB slave
//
// Operation
// - Four FIFOs, eight bytes each, own data register
// - Flags bit 1 is read-only full flag
// - Flags bit 0 is read-only empty flag
// - Flags bits 7:2 reserved, read-only
// - Identification register returns constant code
// - Fourth FIFO flags: same layout, empty after reset
//
// Implementation choice: the APB register port.
`timescale 1ns/10ps
module gfb_top #(
  // Arbitrary neutral value
  parameter logic [7:0] REVISION_CODE = 8'h5A,
  // Arbitrary neutral value
  parameter logic [7:0] IDENT_CODE = 8'hC3
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [gfb_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ
);

  // Match a word address against one register index
  function automatic logic reg_hit(
    input logic [gfb_pkg::ADDR_W-1:0] addr,
    input logic [gfb_pkg::IDX_W-1:0] idx
  );
    return (addr[1:0] == 2'h0) && (addr[gfb_pkg::ADDR_W-1:2] == idx);
  endfunction : reg_hit

  // Find which FIFO a data or flags address belongs to: {hit, fifo number}
  function automatic logic [2:0] fifo_decode(
    input logic [gfb_pkg::ADDR_W-1:0] addr,
    input logic [gfb_pkg::IDX_W-1:0] base
  );
    logic [2:0] res;
    res = 3'h0;
    for (int i = 0; i < gfb_pkg::NUM_FIFOS; i++) begin
      if (reg_hit(addr, base + gfb_pkg::IDX_FIFO_STRIDE * 15'(i))) begin
        res = {1'b1, 2'(i)};
      end
    end
    return res;
  endfunction : fifo_decode

  gfb_pkg::gfb_bus_state_t bus_state_reg, bus_state_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [gfb_pkg::IRQ_W-1:0] irq_status_reg, irq_status_next;
  logic [gfb_pkg::IRQ_W-1:0] irq_enable_reg, irq_enable_next;
  logic irq_reg, irq_next;

  logic access_start;
  logic access_done;
  logic wr_done;
  logic rd_done;
  logic [2:0] data_dec;
  logic [2:0] flags_dec;
  logic mapped;
  logic [gfb_pkg::IRQ_W-1:0] clear_mask;
  logic [gfb_pkg::IRQ_W-1:0] events;

  logic [gfb_pkg::NUM_FIFOS-1:0] fifo_push;
  logic [gfb_pkg::NUM_FIFOS-1:0] fifo_pop;
  logic [gfb_pkg::NUM_FIFOS-1:0] fifo_full;
  logic [gfb_pkg::NUM_FIFOS-1:0] fifo_empty;
  logic [gfb_pkg::DATA_W-1:0] fifo_rdata [0:gfb_pkg::NUM_FIFOS-1];

  // FIFO storage, one instance per data register
  generate
    for (genvar g = 0; g < gfb_pkg::NUM_FIFOS; g++) begin : g_fifo
      gfb_fifo u_fifo (
        .clk(CLK),
        .nrst(NRST),
        .push(fifo_push[g]),
        .pop(fifo_pop[g]),
        .wdata(PWDATA[gfb_pkg::DATA_W-1:0]),
        .rdata(fifo_rdata[g]),
        .full(fifo_full[g]),
        .empty(fifo_empty[g])
      );
    end
  endgenerate

  assign data_dec = fifo_decode(PADDR, gfb_pkg::IDX_FIFO_ONE_DATA);
  assign flags_dec = fifo_decode(PADDR, gfb_pkg::IDX_FIFO_ONE_FLAGS);

  // A transfer is answered one cycle after its first access cycle
  assign access_start = PSEL & PENABLE & (bus_state_reg == gfb_pkg::BUS_IDLE);
  assign access_done = PSEL & PENABLE & (bus_state_reg == gfb_pkg::BUS_DONE);
  assign wr_done = access_done & PWRITE;
  assign rd_done = access_done & ~PWRITE;

  assign mapped = reg_hit(PADDR, gfb_pkg::IDX_SILICON_REVISION)
                | reg_hit(PADDR, gfb_pkg::IDX_DEVICE_IDENTIFICATION)
                | data_dec[2]
                | flags_dec[2]
                | reg_hit(PADDR, gfb_pkg::IDX_IRQ_STATUS)
                | reg_hit(PADDR, gfb_pkg::IDX_IRQ_ENABLE)
                | reg_hit(PADDR, gfb_pkg::IDX_IRQ_CLEAR);

  // Push and pop happen only on the completing edge, so the data latched
  // one cycle earlier is still the head of the FIFO when it is popped
  always_comb begin
    fifo_push = '0;
    fifo_pop = '0;
    events = '0;
    for (int i = 0; i < gfb_pkg::NUM_FIFOS; i++) begin
      if (data_dec[2] && (data_dec[1:0] == 2'(i))) begin
        if (wr_done) begin
          fifo_push[i] = ~fifo_full[i];
          events[gfb_pkg::IRQ_OVERFLOW_BASE + i] = fifo_full[i];
        end
        if (rd_done) begin
          fifo_pop[i] = ~fifo_empty[i];
          // Reading an empty FIFO is a software fault; flag it
          events[gfb_pkg::IRQ_UNDERFLOW_BASE + i] = fifo_empty[i];
        end
      end
    end
  end

  // Bus sequencing
  always_comb begin
    bus_state_next = bus_state_reg;
    pready_next = 1'b0;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    unique case (bus_state_reg)
      gfb_pkg::BUS_IDLE: begin
        if (access_start) begin
          bus_state_next = gfb_pkg::BUS_DONE;
          pready_next = 1'b1;
          pslverr_next = ~mapped;
          prdata_next = 32'h0000_0000;
          if (!PWRITE) begin
            if (reg_hit(PADDR, gfb_pkg::IDX_SILICON_REVISION)) begin
              prdata_next[7:0] = REVISION_CODE;
            end else if (reg_hit(PADDR, gfb_pkg::IDX_DEVICE_IDENTIFICATION)) begin
              prdata_next[7:0] = IDENT_CODE;
            end else if (data_dec[2]) begin
              prdata_next[7:0] = fifo_rdata[data_dec[1:0]];
            end else if (flags_dec[2]) begin
              prdata_next[7:2] = 6'h00;
              prdata_next[gfb_pkg::FLAG_FULL_BIT] = fifo_full[flags_dec[1:0]];
              prdata_next[gfb_pkg::FLAG_EMPTY_BIT] = fifo_empty[flags_dec[1:0]];
            end else if (reg_hit(PADDR, gfb_pkg::IDX_IRQ_STATUS)) begin
              prdata_next[gfb_pkg::IRQ_W-1:0] = irq_status_reg;
            end else if (reg_hit(PADDR, gfb_pkg::IDX_IRQ_ENABLE)) begin
              prdata_next[gfb_pkg::IRQ_W-1:0] = irq_enable_reg;
            end
          end
        end
      end
      gfb_pkg::BUS_DONE: begin
        bus_state_next = gfb_pkg::BUS_IDLE;
      end
    endcase
  end

  // Interrupt status, enable and clear
  always_comb begin
    clear_mask = '0;
    irq_enable_next = irq_enable_reg;
    if (wr_done && reg_hit(PADDR, gfb_pkg::IDX_IRQ_CLEAR)) begin
      clear_mask = PWDATA[gfb_pkg::IRQ_W-1:0];
    end
    if (wr_done && reg_hit(PADDR, gfb_pkg::IDX_IRQ_ENABLE)) begin
      irq_enable_next = PWDATA[gfb_pkg::IRQ_W-1:0];
    end
    // A new event beats a clear in the same cycle
    irq_status_next = (irq_status_reg & ~clear_mask) | events;
    irq_next = |(irq_status_next & irq_enable_next);
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      bus_state_reg <= gfb_pkg::BUS_IDLE;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      bus_state_reg <= bus_state_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      irq_status_reg <= gfb_pkg::IRQ_STATUS_RESET;
      irq_enable_reg <= gfb_pkg::IRQ_ENABLE_RESET;
      irq_reg <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      irq_enable_reg <= irq_enable_next;
      irq_reg <= irq_next;
    end
  end

  assign PRDATA = prdata_reg;
  assign PREADY = pready_reg;
  assign PSLVERR = pslverr_reg;
  assign IRQ = irq_reg;

endmodule : gfb_top

// ===== sim/gfb_chk.sv
// Port-level checker for the FIFO bank
`timescale 1ns/10ps
module gfb_chk #(
  parameter logic [7:0] REVISION_CODE = 8'h5A,
  parameter logic [7:0] IDENT_CODE = 8'hC3
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [gfb_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic IRQ
);
  localparam logic [16:0] A_REV = {gfb_pkg::IDX_SILICON_REVISION, 2'b00};
  localparam logic [16:0] A_ID = {gfb_pkg::IDX_DEVICE_IDENTIFICATION, 2'b00};
  wire rd_done = PREADY && !PWRITE;
  // Flags registers sit at odd indices 0x7F11 to 0x7F17
  wire flg = PADDR[16:6] == 11'h7F1 && PADDR[5] == 1'b0 && PADDR[2] && PADDR[1:0] == 2'b00;
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_ready_delay: assert property ($rose(PENABLE) && PSEL |=> PREADY && PSEL)
    else $error("ready not one cycle after take");
  a_err_with_ready: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
    else $error("error outside a completion");
  a_id_read: assert property (rd_done && PADDR == A_ID |-> PRDATA == {24'h0, IDENT_CODE})
    else $error("identification value wrong");
  a_rev_read: assert property (
    rd_done && PADDR == A_REV |-> PRDATA == {24'h0, REVISION_CODE})
    else $error("revision value wrong");
  a_flags_resv: assert property (rd_done && flg |-> PRDATA[31:2] == 30'h0)
    else $error("reserved flag bits set");
  a_flags_sane: assert property (rd_done && flg |-> PRDATA[1:0] != 2'b11)
    else $error("full and empty together");
  a_irq_cause: assert property (!$stable(IRQ) |-> $past(PREADY))
    else $error("interrupt moved without access");
endmodule : gfb_chk

// ===== sim/gfb_apb_mst.sv
// APB master standing in for the microcontroller core
`timescale 1ns/10ps
module gfb_apb_mst (
  input wire logic CLK,
  output logic PSEL,
  output logic PENABLE,
  output logic PWRITE,
  output logic [16:0] PADDR,
  output logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  initial begin
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 17'h00000;
    PWDATA = 32'h00000000;
  end
  task automatic xfer(input logic w, input logic [14:0] i, input logic [7:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= {i, 2'b00};
    PWDATA <= {24'h000000, d};
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    r = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // Released address and write-data lines toggle so no stale value can be mistaken for a live one
    PADDR <= ~PADDR;
    PWDATA <= ~PWDATA;
  endtask : xfer
endmodule : gfb_apb_mst

// ===== sim/gfb_top_tb_top.sv
// Register-level testbench for the FIFO bank
`timescale 1ns/10ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module gfb_top_tb_top;
  // Arbitrary values
  localparam logic [7:0] REV = 8'h3C;
  localparam logic [7:0] ID = 8'h96;
  localparam logic [14:0] D1 = gfb_pkg::IDX_FIFO_ONE_DATA;
  localparam logic [14:0] IST = gfb_pkg::IDX_IRQ_STATUS;
  logic CLK = 1'b0;
  logic NRST = 1'b0;
  logic PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ;
  logic [16:0] PADDR;
  logic [31:0] PWDATA, PRDATA, r;
  logic e;
  logic [14:0] di;
  int fails = 0;
  int num_checks = 0;
  always #25 CLK = ~CLK;
  gfb_top #(.REVISION_CODE(REV), .IDENT_CODE(ID)) dut (.CLK, .NRST, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .IRQ);
  gfb_apb_mst mst (.CLK, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR);
  task automatic rd(input logic [14:0] i);
    mst.xfer(1'b0, i, 8'h00, r, e);
  endtask : rd
  task automatic wr(input logic [14:0] i, input logic [7:0] d);
    mst.xfer(1'b1, i, d, r, e);
  endtask : wr
  task automatic irq_is(input logic x);
    @(negedge CLK);
    `CHK(IRQ, x)
  endtask : irq_is
  task automatic print_verdict;
    if (fails == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict
  initial begin
    // About ten times the cycles the whole sequence needs
    repeat (6000) @(posedge CLK);
    fails++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge CLK);
    NRST <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      rd(D1 + 15'(2 * k + 1));
      `CHK(r, 32'h00000001)
    end
    wr(gfb_pkg::IDX_DEVICE_IDENTIFICATION, ~ID);
    rd(gfb_pkg::IDX_DEVICE_IDENTIFICATION);
    `CHK(r, {24'h0, ID})
    wr(gfb_pkg::IDX_SILICON_REVISION, ~REV);
    rd(gfb_pkg::IDX_SILICON_REVISION);
    `CHK(r, {24'h0, REV})
    for (int k = 0; k < 4; k++) begin
      di = D1 + 15'(2 * k);
      // Ninth byte overflows and must be dropped
      for (int j = 0; j < 9; j++) wr(di, 8'(16 * k + j));
      for (int j = 0; j < 8; j++) begin
        rd(di + 15'h1);
        `CHK(r[1:0], (j == 0) ? 2'b10 : 2'b00)
        rd(di);
        `CHK(r, 32'(16 * k + j))
      end
      rd(di + 15'h1);
      `CHK(r, 32'h00000001)
    end
    irq_is(1'b0);
    rd(IST);
    `CHK(r, 32'h0000000F)
    wr(gfb_pkg::IDX_IRQ_ENABLE, 8'hFF);
    irq_is(1'b1);
    // Enable register must read back what was written
    rd(gfb_pkg::IDX_IRQ_ENABLE);
    `CHK(r, 32'h000000FF)
    wr(gfb_pkg::IDX_IRQ_CLEAR, 8'h0F);
    irq_is(1'b0);
    rd(D1 + 15'h2);
    `CHK(r, 32'h00000000)
    irq_is(1'b1);
    wr(gfb_pkg::IDX_IRQ_ENABLE, 8'h00);
    irq_is(1'b0);
    rd(IST);
    `CHK(r, 32'h00000020)
    rd(15'h7F30);
    `CHK({e, r}, {1'b1, 32'h0})
    print_verdict();
  end
endmodule : gfb_top_tb_top
bind gfb_top gfb_chk #(.REVISION_CODE(REVISION_CODE), .IDENT_CODE(IDENT_CODE)) chk (.CLK,
  .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .IRQ);
